// ===== rtl/rx_port_irq.sv
// Paged register front end and request combiner for all receive ports
`timescale 1ns/1ps
module rx_port_irq
#(
   parameter int NUM_PORTS = 4
)
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic [NUM_PORTS-1:0] line_length_changed,
   input wire logic [NUM_PORTS-1:0] line_total_changed,
   input wire logic [NUM_PORTS-1:0] overflow_seen,
   input wire logic [NUM_PORTS-1:0] parity_seen,
   input wire logic [NUM_PORTS-1:0] port_valid,
   input wire logic [NUM_PORTS-1:0] lock_level,
   input wire logic [NUM_PORTS*rx_irq_pkg::GPIO_COUNT-1:0] fwd_gpio,
   output logic irq
);
   import rx_irq_pkg::*;

   logic [SEL_WIDTH-1:0] port_select, next_port_select;
   logic [7:0] next_reg_rdata;
   logic next_irq;
   logic [NUM_PORTS-1:0][7:0] ev_status;
   logic [NUM_PORTS-1:0][7:0] ev_enable;
   logic [NUM_PORTS-1:0][7:0] gp_status;
   logic [NUM_PORTS-1:0] unit_irq;
   logic [NUM_PORTS-1:0] rd_first, rd_second, rd_gpio, wr_enable, wr_edge;
   logic rd_act, wr_act;

   // True when port p is the one the select register points at
   function automatic logic port_hit(input logic [SEL_WIDTH-1:0] sel, input int p);
      port_hit = (int'(sel) == p);
   endfunction

   assign rd_act = reg_rd & clk_en;
   assign wr_act = reg_wr & clk_en;

   // Page select register
   always_comb
   begin
      next_port_select = port_select;
      if (wr_act && reg_addr == ADDR_PORT_SELECT)
         next_port_select = reg_wdata[SEL_WIDTH-1:0];
   end

   // Strobes steered to the selected port only
   always_comb
   begin
      for (int p = 0; p < NUM_PORTS; p++)
      begin
         rd_first[p] = rd_act && port_hit(port_select, p)
            && reg_addr == ADDR_STATUS_FIRST;
         rd_second[p] = rd_act && port_hit(port_select, p)
            && reg_addr == ADDR_STATUS_SECOND;
         rd_gpio[p] = rd_act && port_hit(port_select, p)
            && reg_addr == ADDR_GPIO_STATUS;
         wr_enable[p] = wr_act && port_hit(port_select, p)
            && reg_addr == ADDR_EVENT_ENABLE;
         wr_edge[p] = wr_act && port_hit(port_select, p)
            && reg_addr == ADDR_GPIO_EDGE;
      end
   end

   // One unit per receive port
   for (genvar g = 0; g < NUM_PORTS; g++)
   begin : g_port
      port_irq_unit u_unit (
         .clk_sys(clk_sys),
         .rst_n(rst_n),
         .clk_en(clk_en),
         .evt_line_length(line_length_changed[g]),
         .evt_line_total(line_total_changed[g]),
         .evt_overflow(overflow_seen[g]),
         .evt_parity(parity_seen[g]),
         .port_valid(port_valid[g]),
         .lock_level(lock_level[g]),
         .fwd_gpio(fwd_gpio[g*GPIO_COUNT +: GPIO_COUNT]),
         .rd_first(rd_first[g]),
         .rd_second(rd_second[g]),
         .rd_gpio(rd_gpio[g]),
         .wr_enable(wr_enable[g]),
         .wr_edge(wr_edge[g]),
         .wdata(reg_wdata),
         .event_status(ev_status[g]),
         .event_enable(ev_enable[g]),
         .gpio_status(gp_status[g]),
         .irq_req(unit_irq[g])
      );
   end

   // Read data mux, held between reads
   always_comb
   begin
      next_reg_rdata = reg_rdata;
      if (rd_act)
      begin
         case (reg_addr)
            ADDR_PORT_SELECT: next_reg_rdata = {{(8-SEL_WIDTH){1'b0}}, port_select};
            ADDR_EVENT_ENABLE: next_reg_rdata = ev_enable[port_select];
            ADDR_EVENT_STATUS: next_reg_rdata = ev_status[port_select];
            ADDR_GPIO_STATUS: next_reg_rdata = gp_status[port_select];
            default: next_reg_rdata = RESET_BYTE; // Write-only and foreign read as zero
         endcase
      end
   end

   // Single request toward the host
   assign next_irq = |unit_irq;

   // Output and select registers
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         port_select <= RESET_SELECT;
         reg_rdata <= RESET_BYTE;
         irq <= 1'b0;
      end
      else if (clk_en)
      begin
         port_select <= next_port_select;
         reg_rdata <= next_reg_rdata;
         irq <= next_irq;
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   a_irq_raise: assert property (clk_en && (|unit_irq) |=> irq)
      else $error("request not raised");
   a_irq_drop: assert property (clk_en && !(|unit_irq) |=> !irq)
      else $error("request held with nothing pending");
   a_select_routes: assert property (clk_en && reg_rd
      && reg_addr == ADDR_EVENT_STATUS |=> reg_rdata == $past(ev_status[port_select]))
      else $error("status read from wrong port");
   a_reserved_zero: assert property (clk_en && reg_rd
      && reg_addr == ADDR_EVENT_STATUS |=> reg_rdata[7] == 1'b0 && reg_rdata[3] == 1'b0)
      else $error("reserved status bits not zero");
   a_gpio_level_read: assert property (clk_en && reg_rd
      && reg_addr == ADDR_GPIO_STATUS |=> reg_rdata[3:0] == $past(gp_status[port_select][3:0]))
      else $error("gpio level readback mismatch");
   a_enable_readback: assert property (clk_en && reg_wr
      && reg_addr == ADDR_EVENT_ENABLE
      |=> ev_enable[port_select] == ($past(reg_wdata) & MASK_EVENT_USED))
      else $error("enable write lost");

   // Clock enable low freezes the front end
   a_select_frozen: assert property (!clk_en |=> $stable(port_select))
      else $error("page select moved while frozen");
   a_rdata_frozen: assert property (!clk_en |=> $stable(reg_rdata))
      else $error("read data moved while frozen");
   a_irq_frozen: assert property (!clk_en |=> $stable(irq))
      else $error("request moved while frozen");

   // Page select write and readback
   a_select_write: assert property (clk_en && reg_wr
      && reg_addr == ADDR_PORT_SELECT |=> port_select == $past(reg_wdata[SEL_WIDTH-1:0]))
      else $error("page select write lost");
   a_select_read: assert property (clk_en && reg_rd
      && reg_addr == ADDR_PORT_SELECT
      |=> reg_rdata == {{(8-SEL_WIDTH){1'b0}}, $past(port_select)})
      else $error("page select readback mismatch");

   // Per-port strobes reach the selected port and no other
   a_read_one_port: assert property (|(rd_first | rd_second | rd_gpio)
      |-> (rd_first | rd_second | rd_gpio) == (NUM_PORTS'(1) << port_select))
      else $error("read strobe on unselected port");
   a_write_one_port: assert property (|(wr_enable | wr_edge)
      |-> (wr_enable | wr_edge) == (NUM_PORTS'(1) << port_select))
      else $error("write strobe on unselected port");

   // Edge enable and clear-only addresses read back zero
   a_edge_reads_zero: assert property (clk_en && reg_rd
      && reg_addr == ADDR_GPIO_EDGE |=> reg_rdata == RESET_BYTE)
      else $error("write-only register read back nonzero");
   a_clear_reads_zero: assert property (clk_en && reg_rd
      && (reg_addr == ADDR_STATUS_FIRST || reg_addr == ADDR_STATUS_SECOND)
      |=> reg_rdata == RESET_BYTE)
      else $error("clear address read back nonzero");

   // Enable and pending GPIO readback come from the selected port
   a_enable_routes: assert property (clk_en && reg_rd
      && reg_addr == ADDR_EVENT_ENABLE |=> reg_rdata == $past(ev_enable[port_select]))
      else $error("enable read from wrong port");
   a_gpio_pend_read: assert property (clk_en && reg_rd
      && reg_addr == ADDR_GPIO_STATUS |=> reg_rdata[7:4] == $past(gp_status[port_select][7:4]))
      else $error("gpio pending readback mismatch");
   a_rdata_held: assert property (!(clk_en && reg_rd) |=> $stable(reg_rdata))
      else $error("read data changed without a read");

   // Main scenarios worth seeing
   c_irq_cycle: cover property (irq ##[1:40] !irq);
   c_page_switch: cover property (reg_wr && reg_addr == ADDR_PORT_SELECT ##[1:10] reg_rd);
   c_all_pending: cover property (&unit_irq);
endmodule // rx_port_irq

// ===== rtl/rx_irq_pkg.sv
// Constants shared by the receive-port interrupt status block
package rx_irq_pkg;
   localparam int SEL_WIDTH = 2;
   localparam int GPIO_COUNT = 4;
   localparam logic [7:0] ADDR_PORT_SELECT = 8'h4c;
   localparam logic [7:0] ADDR_STATUS_FIRST = 8'h4d;
   localparam logic [7:0] ADDR_STATUS_SECOND = 8'h4e;
   localparam logic [7:0] ADDR_EVENT_ENABLE = 8'hd9;
   localparam logic [7:0] ADDR_EVENT_STATUS = 8'hdb;
   localparam logic [7:0] ADDR_GPIO_STATUS = 8'hdc;
   localparam logic [7:0] ADDR_GPIO_EDGE = 8'hdd;
   localparam int BIT_LINE_LENGTH = 6;
   localparam int BIT_LINE_TOTAL = 5;
   localparam int BIT_OVERFLOW = 4;
   localparam int BIT_PARITY = 2;
   localparam int BIT_VALID = 1;
   localparam int BIT_LOCK = 0;
   localparam int GPIO_PEND_LSB = 4;
   localparam logic [7:0] MASK_FIRST = 8'h07;
   localparam logic [7:0] MASK_SECOND = 8'h70;
   localparam logic [7:0] MASK_EVENT_USED = 8'h77;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [SEL_WIDTH-1:0] RESET_SELECT = 2'h0;
   localparam logic [GPIO_COUNT-1:0] RESET_GPIO = 4'h0;
endpackage

// ===== rtl/port_irq_unit.sv
// Per-port event latches, enables and forward GPIO edge detection
`timescale 1ns/1ps
module port_irq_unit
   import rx_irq_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic evt_line_length,
   input wire logic evt_line_total,
   input wire logic evt_overflow,
   input wire logic evt_parity,
   input wire logic port_valid,
   input wire logic lock_level,
   input wire logic [rx_irq_pkg::GPIO_COUNT-1:0] fwd_gpio,
   input wire logic rd_first,
   input wire logic rd_second,
   input wire logic rd_gpio,
   input wire logic wr_enable,
   input wire logic wr_edge,
   input wire logic [7:0] wdata,
   output logic [7:0] event_status,
   output logic [7:0] event_enable,
   output logic [7:0] gpio_status,
   output logic irq_req
);
   import rx_irq_pkg::*;

   logic [7:0] pend, next_pend;
   logic [7:0] enable, next_enable;
   logic [7:0] edge_en, next_edge_en;
   logic [GPIO_COUNT-1:0] gpio_pend, next_gpio_pend;
   logic [GPIO_COUNT-1:0] gpio_prev;
   logic valid_prev, lock_prev;
   logic [7:0] sets;
   logic [GPIO_COUNT-1:0] gpio_sets;

   // Event sources and enabled GPIO edges
   always_comb
   begin
      sets = RESET_BYTE;
      gpio_sets = RESET_GPIO;
      sets[BIT_LINE_LENGTH] = evt_line_length;
      sets[BIT_LINE_TOTAL] = evt_line_total;
      sets[BIT_OVERFLOW] = evt_overflow;
      sets[BIT_PARITY] = evt_parity;
      sets[BIT_VALID] = port_valid ^ valid_prev;
      sets[BIT_LOCK] = lock_level ^ lock_prev;
      for (int i = 0; i < GPIO_COUNT; i++)
      begin
         gpio_sets[i] = (fwd_gpio[i] & ~gpio_prev[i] & edge_en[2*i])
            | (~fwd_gpio[i] & gpio_prev[i] & edge_en[2*i+1]);
      end
   end

   // Clear on status read, a same-cycle event wins
   always_comb
   begin
      next_pend = pend;
      if (rd_first)
         next_pend = next_pend & ~MASK_FIRST;
      if (rd_second)
         next_pend = next_pend & ~MASK_SECOND;
      next_pend = next_pend | sets;
      next_gpio_pend = rd_gpio ? RESET_GPIO : gpio_pend;
      next_gpio_pend = next_gpio_pend | gpio_sets;
      next_enable = wr_enable ? (wdata & MASK_EVENT_USED) : enable;
      next_edge_en = wr_edge ? wdata : edge_en;
   end

   // State registers, frozen while clock enable is low
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pend <= RESET_BYTE;
         enable <= RESET_BYTE;
         edge_en <= RESET_BYTE;
         gpio_pend <= RESET_GPIO;
         gpio_prev <= RESET_GPIO;
         valid_prev <= 1'b0;
         lock_prev <= 1'b0;
      end
      else if (clk_en)
      begin
         pend <= next_pend;
         enable <= next_enable;
         edge_en <= next_edge_en;
         gpio_pend <= next_gpio_pend;
         gpio_prev <= fwd_gpio;
         valid_prev <= port_valid;
         lock_prev <= lock_level;
      end
   end

   // Readback views and the port request
   assign event_status = pend;
   assign event_enable = enable;
   assign gpio_status = {gpio_pend, fwd_gpio};
   assign irq_req = (|(pend & enable)) | (|gpio_pend);

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   a_lock_change_sets: assert property (clk_en && (lock_level != lock_prev) |=> pend[0])
      else $error("lock change not latched");
   a_valid_change_sets: assert property (clk_en && (port_valid != valid_prev) |=> pend[1])
      else $error("valid change not latched");
   a_parity_sets: assert property (clk_en && evt_parity |=> pend[2])
      else $error("parity error not latched");
   a_overflow_sets: assert property (clk_en && evt_overflow |=> pend[4])
      else $error("overflow not latched");
   a_total_sets: assert property (clk_en && evt_line_total |=> pend[5])
      else $error("line total change not latched");
   a_length_sets: assert property (clk_en && evt_line_length |=> pend[6])
      else $error("line length change not latched");
   a_first_clears: assert property (clk_en && rd_first && !evt_parity
      && (port_valid == valid_prev) && (lock_level == lock_prev) |=> pend[2:0] == 3'h0)
      else $error("first status read did not clear");
   a_second_clears: assert property (clk_en && rd_second && !evt_line_length
      && !evt_line_total && !evt_overflow |=> pend[6:4] == 3'h0)
      else $error("second status read did not clear");
   a_gpio_rise: assert property (clk_en && fwd_gpio[0] && !gpio_prev[0]
      && edge_en[0] |=> gpio_pend[0])
      else $error("rise edge not latched");
   a_gpio_fall: assert property (clk_en && !fwd_gpio[3] && gpio_prev[3]
      && edge_en[7] |=> gpio_pend[3])
      else $error("fall edge not latched");
   a_gpio_rc: assert property (clk_en && rd_gpio && (gpio_sets == RESET_GPIO)
      |=> gpio_pend == RESET_GPIO)
      else $error("gpio pending not cleared on read");
   a_masked_quiet: assert property (clk_en && !wr_enable && (enable == RESET_BYTE)
      && (gpio_pend == RESET_GPIO) && (gpio_sets == RESET_GPIO) |=> !irq_req)
      else $error("request without enabled pending bit");
   c_lock_event: cover property (clk_en && lock_level != lock_prev ##1 rd_first);
   c_gpio_edge: cover property (clk_en && gpio_sets[1] ##[1:20] rd_gpio);
endmodule // port_irq_unit

// ===== test/host_model.sv
// Register host that makes one strobed access at a time
`timescale 1ns/1ps
module host_model
(
   input wire logic clk_sys,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   // Idle bus at time zero
   initial
   begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end

   // One write; strobe held for one clock, then address and data inverted
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask

   // One read; data taken once the strobe edge has landed
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      #1 d = reg_rdata;
   endtask
endmodule // host_model

// ===== test/rx_port_irq_tb.sv
// Self-checking bench for the receive-port interrupt status block
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fails++; \
   $display("Error %0t: got %h want %h", $time, a, e); end end
module rx_port_irq_tb;
   import rx_irq_pkg::*;
   localparam int NP = 4;
   typedef struct { int kind; logic [7:0] exp_status; logic [7:0] clear_addr; } row_t;
   logic clk_sys, rst_n, clk_en, reg_wr, reg_rd, irq;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
   logic [NP-1:0] ll, lt, ov, pa, pv, lk;
   logic [NP*GPIO_COUNT-1:0] fwd_gpio;
   row_t rows [6];
   logic [7:0] reset_addrs [6] = '{8'h4c, 8'hd9, 8'hdb, 8'hdc, 8'hdd, 8'h10};
   int fails, checks_done;

   rx_port_irq #(.NUM_PORTS(NP)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .line_length_changed(ll), .line_total_changed(lt),
      .overflow_seen(ov), .parity_seen(pa), .port_valid(pv), .lock_level(lk),
      .fwd_gpio(fwd_gpio), .irq(irq));
   host_model host (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

   // Free-running clock
   initial
   begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   // Verdict and end of run
   task automatic complete_run;
      if (fails == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Read one register and compare
   task automatic check_read(input logic [7:0] a, input logic [7:0] e);
      host.rd(a, rd_val);
      `CHK(rd_val, e)
   endtask

   // One event on a port: pulse for one edge, or a level toggle
   task automatic fire(input int p, input int k);
      @(posedge clk_sys);
      case (k)
         0: ll[p] <= 1'b1;
         1: lt[p] <= 1'b1;
         2: ov[p] <= 1'b1;
         3: pa[p] <= 1'b1;
         4: pv[p] <= ~pv[p];
         default: lk[p] <= ~lk[p];
      endcase
      @(posedge clk_sys);
      ll <= '0;
      lt <= '0;
      ov <= '0;
      pa <= '0;
   endtask

   // Change one forward GPIO level
   task automatic set_gpio(input int b, input logic v);
      @(posedge clk_sys);
      fwd_gpio[b] <= v;
      #1;
   endtask

   // Hang guard
   initial
   begin
      repeat (5000) @(posedge clk_sys);
      fails++;
      complete_run;
   end

   // Main sequence
   initial
   begin
      int p;
      rows[0] = '{0, 8'h40, ADDR_STATUS_SECOND};
      rows[1] = '{1, 8'h20, ADDR_STATUS_SECOND};
      rows[2] = '{2, 8'h10, ADDR_STATUS_SECOND};
      rows[3] = '{3, 8'h04, ADDR_STATUS_FIRST};
      rows[4] = '{4, 8'h02, ADDR_STATUS_FIRST};
      rows[5] = '{5, 8'h01, ADDR_STATUS_FIRST};
      {ll, lt, ov, pa, pv, lk} = '0;
      fwd_gpio = '0;
      clk_en = 1'b1;
      rst_n = 1'b0;
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      // Reset values, write-only and unmapped places read zero
      host.wr(8'h10, 8'hff);
      host.wr(ADDR_GPIO_EDGE, 8'h00);
      for (int i = 0; i < 6; i++)
         check_read(reset_addrs[i], 8'h00);
      host.wr(ADDR_PORT_SELECT, 8'hfe);
      check_read(ADDR_PORT_SELECT, 8'h02);
      // Each event kind: set, survive the wrong clear, stay on its port, clear
      for (int i = 0; i < 6; i++)
      begin
         p = i % NP;
         host.wr(ADDR_PORT_SELECT, 8'(p));
         host.wr(ADDR_EVENT_ENABLE, MASK_EVENT_USED);
         fire(p, rows[i].kind);
         check_read(ADDR_EVENT_STATUS, rows[i].exp_status);
         `CHK(irq, 1'b1)
         host.rd(rows[i].clear_addr ^ 8'h03, rd_val);
         check_read(ADDR_EVENT_STATUS, rows[i].exp_status);
         host.wr(ADDR_PORT_SELECT, 8'(p ^ 1));
         check_read(ADDR_EVENT_STATUS, 8'h00);
         host.wr(ADDR_PORT_SELECT, 8'(p));
         host.rd(rows[i].clear_addr, rd_val);
         check_read(ADDR_EVENT_STATUS, 8'h00);
         `CHK(irq, 1'b0)
         host.wr(ADDR_EVENT_ENABLE, 8'h00);
      end
      // Disabled event latches but raises no request
      host.wr(ADDR_PORT_SELECT, 8'h00);
      fire(0, 3);
      repeat (2) @(posedge clk_sys);
      #1;
      `CHK(irq, 1'b0)
      check_read(ADDR_EVENT_STATUS, 8'h04);
      host.rd(ADDR_STATUS_FIRST, rd_val);
      // Forward GPIO edges on port 2: gpio0 rise and gpio3 fall enabled
      host.wr(ADDR_PORT_SELECT, 8'h02);
      host.wr(ADDR_GPIO_EDGE, 8'h81);
      set_gpio(8, 1'b1);
      check_read(ADDR_GPIO_STATUS, 8'h11);
      `CHK(irq, 1'b1)
      check_read(ADDR_GPIO_STATUS, 8'h01);
      set_gpio(11, 1'b1);
      `CHK(irq, 1'b0)
      check_read(ADDR_GPIO_STATUS, 8'h09);
      set_gpio(11, 1'b0);
      check_read(ADDR_GPIO_STATUS, 8'h81);
      set_gpio(8, 1'b0);
      check_read(ADDR_GPIO_STATUS, 8'h00);
      // Clock enable low: a page write and an event are both ignored
      @(posedge clk_sys);
      clk_en <= 1'b0;
      host.wr(ADDR_PORT_SELECT, 8'h01);
      fire(2, 2);
      @(posedge clk_sys);
      clk_en <= 1'b1;
      check_read(ADDR_PORT_SELECT, 8'h02);
      check_read(ADDR_EVENT_STATUS, 8'h00);
      // Mid-run reset drops pending state, enables, page and outputs
      host.wr(ADDR_EVENT_ENABLE, 8'hff);
      check_read(ADDR_EVENT_ENABLE, MASK_EVENT_USED);
      fire(2, 0);
      check_read(ADDR_PORT_SELECT, 8'h02);
      `CHK(irq, 1'b1)
      @(posedge clk_sys);
      rst_n <= 1'b0;
      @(posedge clk_sys);
      #1;
      `CHK(irq, 1'b0)
      `CHK(reg_rdata, 8'h00)
      @(posedge clk_sys);
      rst_n <= 1'b1;
      check_read(ADDR_PORT_SELECT, 8'h00);
      host.wr(ADDR_PORT_SELECT, 8'h02);
      check_read(ADDR_EVENT_ENABLE, 8'h00);
      check_read(ADDR_EVENT_STATUS, 8'h00);
      complete_run;
   end
endmodule // rx_port_irq_tb
